//--- tttc_pkg.sv
// Package: register map, field positions and frame constants for the transmit transparency block
package tttc_pkg;
  localparam int unsigned   CHANNELS      = 24;
  localparam int unsigned   BITS_PER_CH   = 8;
  localparam int unsigned   ADDR_W        = 12;
  // Printed offsets are not word multiples: they are indices, byte address is four times
  localparam logic [9:0]    IDX_MASK_1_8  = 10'h039;
  localparam logic [9:0]    IDX_MASK_9_16 = 10'h03A;
  localparam logic [9:0]    IDX_MASK_17_24 = 10'h03B;
  localparam logic [9:0]    IDX_TX_CTRL   = 10'h040;
  localparam logic [7:0]    MASK_RESET    = 8'h00;
  // Transmit control register fields
  localparam int unsigned   CTRL_FORCE_A  = 0;
  localparam int unsigned   CTRL_FORCE_B  = 1;
  localparam int unsigned   CTRL_D4       = 2;
  localparam int unsigned   CTRL_YELLOW   = 3;
  localparam int unsigned   CTRL_RBS_EN   = 4;
  localparam int unsigned   CTRL_STUFF_EN = 5;
  localparam int unsigned   CTRL_W        = 6;
  localparam logic [5:0]    CTRL_RESET    = 6'h00;
  // Bit positions in a channel byte, MSB (bit 1) is transmitted first
  localparam int unsigned   POS_BIT2      = 6;
  localparam int unsigned   POS_BIT7      = 1;
  localparam int unsigned   POS_BIT8      = 0;
  localparam logic [31:0]   SLV_ERR_DATA  = 32'h0000_0000;
endpackage

//--- tttc_chan_proc.sv
// One DS0 channel byte: signaling insertion, bit 7 stuffing and yellow alarm overwrite
module tttc_chan_proc
(
  input  wire logic [7:0] data_in,
  input  wire logic       clear_in,
  input  wire logic       rbs_frame_in,
  input  wire logic       sig_bit_in,
  input  wire logic       stuff_req_in,
  input  wire logic       force_stuff_in,
  input  wire logic       yellow_d4_in,
  output logic      [7:0] data_out
);
  import tttc_pkg::*;

  always_comb begin
    data_out = data_in;
    if (rbs_frame_in && !clear_in) begin
      data_out[POS_BIT8] = sig_bit_in;
    end
    if (stuff_req_in && (!clear_in || force_stuff_in)) begin
      data_out[POS_BIT7] = 1'b1;
    end
    if (yellow_d4_in) begin
      data_out[POS_BIT2] = 1'b0;
    end
  end
endmodule

//--- tttc_tx_transparency.sv
// Top level: transmit clear-channel control with APB register access
// Overview of operation
// - Each of the 24 transmit channels has one mask bit, channel 1 at bit 0 of the first mask register up to channel 24 at bit 7 of the third.
// - A mask bit of 1 marks its channel clear and a 0 marks it non-transparent.
// - A clear channel never gets robbed-bit signaling written into its data.
// - A clear channel never gets bit 7 stuffing unless the global stuffing override is on.
// - In D4 framing with yellow alarm sent, bit 2 of every channel is forced to 0, clear or not.
// - With both override bits set, all 24 channels are stuffed and the masks only steer signaling.
//
// Added by the designer: the APB register port.
module tttc_tx_transparency
(
  input  wire logic                          mclk_in,
  input  wire logic                          nrst_in,
  input  wire logic                          ce_in,
  input  wire logic                          psel_in,
  input  wire logic                          penable_in,
  input  wire logic                          pwrite_in,
  input  wire logic [tttc_pkg::ADDR_W-1:0]   paddr_in,
  input  wire logic [31:0]                   pwdata_in,
  input  wire logic [3:0]                    pstrb_in,
  output logic      [31:0]                   prdata_out,
  output logic                               pready_out,
  output logic                               pslverr_out,
  input  wire logic                          ch_valid_in,
  input  wire logic [4:0]                    ch_index_in,
  input  wire logic [7:0]                    ch_data_in,
  input  wire logic                          rbs_frame_in,
  input  wire logic                          sig_bit_in,
  input  wire logic                          stuff_req_in,
  output logic                               ch_valid_out,
  output logic      [4:0]                    ch_index_out,
  output logic      [7:0]                    ch_data_out,
  output logic      [tttc_pkg::CHANNELS-1:0] clear_mask_out
);
  import tttc_pkg::*;

  // ----------------------------------------------------------------
  // Register file
  // ----------------------------------------------------------------
  logic [CHANNELS-1:0] mask_q, mask_d;
  logic [CTRL_W-1:0]   ctrl_q, ctrl_d;
  logic [31:0]         prdata_q, prdata_d;
  logic                pslverr_q, pslverr_d;
  logic [9:0]          idx;
  logic                aligned;
  logic                hit_m1, hit_m2, hit_m3, hit_ctl, mapped;
  logic                access;

  assign idx     = paddr_in[ADDR_W-1:2];
  assign aligned = (paddr_in[1:0] == 2'b00);
  assign hit_m1  = aligned && (idx == IDX_MASK_1_8);
  assign hit_m2  = aligned && (idx == IDX_MASK_9_16);
  assign hit_m3  = aligned && (idx == IDX_MASK_17_24);
  assign hit_ctl = aligned && (idx == IDX_TX_CTRL);
  assign mapped  = hit_m1 || hit_m2 || hit_m3 || hit_ctl;
  // pready follows ce_in: an access completes in its first access cycle while ce_in is high
  assign access  = psel_in && penable_in && ce_in;

  always_comb begin
    mask_d    = mask_q;
    ctrl_d    = ctrl_q;
    prdata_d  = prdata_q;
    pslverr_d = 1'b0;
    if (psel_in && !penable_in) begin
      // Setup phase: prepare read data so it is registered for the access phase
      prdata_d = 32'h0000_0000;
      if (hit_m1) begin
        prdata_d[7:0] = mask_q[7:0];
      end else if (hit_m2) begin
        prdata_d[7:0] = mask_q[15:8];
      end else if (hit_m3) begin
        prdata_d[7:0] = mask_q[23:16];
      end else if (hit_ctl) begin
        prdata_d[CTRL_W-1:0] = ctrl_q;
      end else begin
        prdata_d = SLV_ERR_DATA;
      end
      pslverr_d = !mapped;
    end
    if (access && pwrite_in && pstrb_in[0]) begin
      if (hit_m1) begin
        mask_d[7:0] = pwdata_in[7:0];
      end
      if (hit_m2) begin
        mask_d[15:8] = pwdata_in[7:0];
      end
      if (hit_m3) begin
        mask_d[23:16] = pwdata_in[7:0];
      end
      if (hit_ctl) begin
        ctrl_d = pwdata_in[CTRL_W-1:0];
      end
    end
    if (access) begin
      pslverr_d = pslverr_q;
    end
  end

  always_ff @(posedge mclk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      mask_q    <= {3{MASK_RESET}};
      ctrl_q    <= CTRL_RESET;
      prdata_q  <= 32'h0000_0000;
      pslverr_q <= 1'b0;
    end else if (ce_in) begin
      mask_q    <= mask_d;
      ctrl_q    <= ctrl_d;
      prdata_q  <= prdata_d;
      pslverr_q <= pslverr_d;
    end
  end

  assign pready_out     = ce_in;
  assign prdata_out     = prdata_q;
  assign pslverr_out    = pslverr_q && psel_in && penable_in;
  assign clear_mask_out = mask_q;

  // ----------------------------------------------------------------
  // Channel data path
  // ----------------------------------------------------------------
  logic       clear_sel;
  logic       force_stuff;
  logic       yellow_d4;
  logic [7:0] proc_data;
  logic       vld_q, vld_d;
  logic [4:0] cidx_q, cidx_d;
  logic [7:0] cdat_q, cdat_d;

  // Out-of-range channel index is treated as non-transparent
  assign clear_sel   = (ch_index_in < 5'(CHANNELS)) ? mask_q[ch_index_in] : 1'b0;
  assign force_stuff = ctrl_q[CTRL_FORCE_A] && ctrl_q[CTRL_FORCE_B];
  assign yellow_d4   = ctrl_q[CTRL_D4] && ctrl_q[CTRL_YELLOW];

  tttc_chan_proc u_chan (
    .data_in        (ch_data_in),
    .clear_in       (clear_sel),
    .rbs_frame_in   (rbs_frame_in && ctrl_q[CTRL_RBS_EN]),
    .sig_bit_in     (sig_bit_in),
    .stuff_req_in   (stuff_req_in && ctrl_q[CTRL_STUFF_EN]),
    .force_stuff_in (force_stuff),
    .yellow_d4_in   (yellow_d4),
    .data_out       (proc_data)
  );

  always_comb begin
    vld_d  = ch_valid_in;
    cidx_d = cidx_q;
    cdat_d = cdat_q;
    if (ch_valid_in) begin
      cidx_d = ch_index_in;
      cdat_d = proc_data;
    end
  end

  always_ff @(posedge mclk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      vld_q  <= 1'b0;
      cidx_q <= 5'h00;
      cdat_q <= 8'h00;
    end else if (ce_in) begin
      vld_q  <= vld_d;
      cidx_q <= cidx_d;
      cdat_q <= cdat_d;
    end
  end

  assign ch_valid_out = vld_q;
  assign ch_index_out = cidx_q;
  assign ch_data_out  = cdat_q;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  property p_mask_write;
    @(posedge mclk_in) disable iff (!nrst_in)
      (access && pwrite_in && pstrb_in[0] && hit_m3) |=> (mask_q[23:16] == $past(pwdata_in[7:0]));
  endproperty
  a_mask_write: assert property (p_mask_write) else $error("mask 17-24 not written");

  property p_clear_no_rbs;
    @(posedge mclk_in) disable iff (!nrst_in)
      (ce_in && ch_valid_in && clear_sel && rbs_frame_in && !yellow_d4)
      |=> (ch_data_out[POS_BIT8] == $past(ch_data_in[POS_BIT8]));
  endproperty
  a_clear_no_rbs: assert property (p_clear_no_rbs) else $error("signaling hit a clear channel");

  property p_clear_no_stuff;
    @(posedge mclk_in) disable iff (!nrst_in)
      (ce_in && ch_valid_in && clear_sel && !force_stuff)
      |=> (ch_data_out[POS_BIT7] == $past(ch_data_in[POS_BIT7]));
  endproperty
  a_clear_no_stuff: assert property (p_clear_no_stuff) else $error("clear channel stuffed");

  property p_yellow;
    @(posedge mclk_in) disable iff (!nrst_in)
      (ce_in && ch_valid_in && yellow_d4) |=> (ch_valid_out && !ch_data_out[POS_BIT2]);
  endproperty
  a_yellow: assert property (p_yellow) else $error("yellow bit 2 not forced");

  property p_force_stuff;
    @(posedge mclk_in) disable iff (!nrst_in)
      (ce_in && ch_valid_in && force_stuff && stuff_req_in && ctrl_q[CTRL_STUFF_EN])
      |=> ch_data_out[POS_BIT7];
  endproperty
  a_force_stuff: assert property (p_force_stuff) else $error("override stuffing missed");

  property p_nonclear_rbs;
    @(posedge mclk_in) disable iff (!nrst_in)
      (ce_in && ch_valid_in && !clear_sel && rbs_frame_in && ctrl_q[CTRL_RBS_EN])
      |=> (ch_data_out[POS_BIT8] == $past(sig_bit_in));
  endproperty
  a_nonclear_rbs: assert property (p_nonclear_rbs) else $error("signaling missed");

  // Taken from the raw mask bit, so a misrouted channel select is caught
  property p_clear_sel;
    @(posedge mclk_in) disable iff (!nrst_in)
      (ce_in && ch_valid_in && (ch_index_in == 5'h00) && mask_q[0] && rbs_frame_in
       && ctrl_q[CTRL_RBS_EN])
      |=> (ch_data_out[POS_BIT8] == $past(ch_data_in[POS_BIT8]));
  endproperty
  a_clear_sel: assert property (p_clear_sel) else $error("channel 1 mask misrouted");

  property p_nonclear_stuff;
    @(posedge mclk_in) disable iff (!nrst_in)
      (ce_in && ch_valid_in && !clear_sel && stuff_req_in && ctrl_q[CTRL_STUFF_EN])
      |=> ch_data_out[POS_BIT7];
  endproperty
  a_nonclear_stuff: assert property (p_nonclear_stuff) else $error("stuffing missed");
endmodule

//--- tb_top.sv
// Self-checking bench for the transmit clear-channel block
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import tttc_pkg::*;
  logic mclk_in, nrst_in, ce_in, psel_in, penable_in, pwrite_in;
  logic [ADDR_W-1:0] paddr_in;
  logic [31:0] pwdata_in, prdata_out;
  logic [3:0] pstrb_in;
  logic pready_out, pslverr_out, ch_valid_in, rbs_frame_in, sig_bit_in, stuff_req_in, ch_valid_out;
  logic [4:0] ch_idx_in, ch_index_out;
  logic [7:0] ch_data_in, ch_data_out;
  logic [CHANNELS-1:0] clear_mask_out;
  int bad_count, total_checks;
  tttc_tx_transparency i_dut (.mclk_in(mclk_in), .nrst_in(nrst_in), .ce_in(ce_in),
    .psel_in(psel_in), .penable_in(penable_in), .pwrite_in(pwrite_in), .paddr_in(paddr_in),
    .pwdata_in(pwdata_in), .pstrb_in(pstrb_in), .prdata_out(prdata_out),
    .pready_out(pready_out), .pslverr_out(pslverr_out), .ch_valid_in(ch_valid_in),
    .ch_index_in(ch_idx_in), .ch_data_in(ch_data_in), .rbs_frame_in(rbs_frame_in),
    .sig_bit_in(sig_bit_in), .stuff_req_in(stuff_req_in), .ch_valid_out(ch_valid_out),
    .ch_index_out(ch_index_out), .ch_data_out(ch_data_out), .clear_mask_out(clear_mask_out));
  // ------------------------------------------------------------
  // Checking and bus tasks
  // ------------------------------------------------------------
  task automatic cmp(input string what, input logic [31:0] exp, input logic [31:0] got);
    total_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic apb(input logic wr, input logic [9:0] idx, input logic [31:0] wd,
                     output logic [31:0] rd, output logic err);
    int n;
    n = 0;
    @(posedge mclk_in);
    psel_in <= 1'b1; pwrite_in <= wr; paddr_in <= {idx, 2'b00}; pwdata_in <= wd;
    @(posedge mclk_in);
    penable_in <= 1'b1;
    // Master holds the request until pready is seen at a rising edge
    do begin
      @(posedge mclk_in);
      n++;
    end while (pready_out !== 1'b1 && n < 50);
    rd = prdata_out;
    err = pslverr_out;
    if (n >= 50) cmp("pready", 1, 0);
    psel_in <= 1'b0; penable_in <= 1'b0;
  endtask
  task automatic send(input logic [4:0] idx, input logic [7:0] exp);
    @(posedge mclk_in);
    ch_valid_in <= 1'b1; ch_idx_in <= idx; ch_data_in <= 8'h44;
    rbs_frame_in <= 1'b1; sig_bit_in <= 1'b1; stuff_req_in <= 1'b1;
    @(posedge mclk_in);
    ch_valid_in <= 1'b0;
    #1;
    cmp("ch_valid_out", 1, ch_valid_out);
    cmp("ch_index_out", idx, ch_index_out);
    cmp("ch_data_out", exp, ch_data_out);
  endtask
  // ------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------
  task automatic t_regs;
    logic [31:0] rd;
    logic e;
    apb(0, IDX_MASK_1_8, 0, rd, e); cmp("mask1 reset", MASK_RESET, rd);
    apb(0, IDX_MASK_17_24, 0, rd, e); cmp("mask3 reset", MASK_RESET, rd);
    apb(1, IDX_MASK_1_8, 32'h01, rd, e);
    apb(1, IDX_MASK_9_16, 32'h00, rd, e);
    apb(1, IDX_MASK_17_24, 32'h80, rd, e);
    apb(0, IDX_MASK_17_24, 0, rd, e); cmp("mask3 read", 32'h80, rd);
    cmp("clear mask", 32'h0080_0001, {8'h00, clear_mask_out});
    apb(0, 10'h001, 0, rd, e); cmp("unmapped err", 1, e);
    cmp("unmapped rd", 32'h0000_0000, rd);
    $display("test regs done");
  endtask
  // Clear channels 1 and 24, channel 2 not clear; table of control settings
  task automatic t_modes;
    logic [31:0] rd;
    logic e;
    logic [5:0] c;
    logic [7:0] ec, en;
    logic [5:0] ctl[4] = '{6'h30, 6'h31, 6'h33, 6'h3C};
    for (int i = 0; i < 4; i++) begin
      c = ctl[i];
      apb(1, IDX_TX_CTRL, {26'h0, c}, rd, e);
      ec = 8'h44;
      en = 8'h47;
      if (c[CTRL_FORCE_A] && c[CTRL_FORCE_B]) ec[POS_BIT7] = 1'b1;
      if (c[CTRL_D4] && c[CTRL_YELLOW]) begin
        ec[POS_BIT2] = 1'b0;
        en[POS_BIT2] = 1'b0;
      end
      send(5'd0, ec);
      send(5'd23, ec);
      send(5'd1, en);
    end
    $display("test modes done");
  endtask
  // Enables off, out-of-range index, clock enable freeze and a mid-run reset
  task automatic t_misc;
    logic [31:0] rd;
    logic e;
    apb(0, IDX_TX_CTRL, 0, rd, e); cmp("ctrl read", 32'h3C, rd);
    apb(1, IDX_TX_CTRL, 32'h03, rd, e);
    send(5'd1, 8'h44);
    send(5'd0, 8'h44);
    apb(1, IDX_TX_CTRL, 32'h30, rd, e);
    send(5'd24, 8'h47);
    @(posedge mclk_in);
    ce_in <= 1'b0;
    ch_valid_in <= 1'b1;
    #1;
    cmp("valid after one cycle", 0, ch_valid_out);
    cmp("pready frozen", 0, pready_out);
    repeat (2) @(posedge mclk_in);
    #1;
    cmp("valid frozen", 0, ch_valid_out);
    cmp("data frozen", 8'h47, ch_data_out);
    @(posedge mclk_in);
    ce_in <= 1'b1;
    ch_valid_in <= 1'b0;
    @(posedge mclk_in);
    nrst_in <= 1'b0;
    repeat (2) @(posedge mclk_in);
    nrst_in <= 1'b1;
    #1;
    cmp("mask after reset", {8'h00, {3{MASK_RESET}}}, {8'h00, clear_mask_out});
    apb(0, IDX_MASK_1_8, 0, rd, e); cmp("mask1 after reset", MASK_RESET, rd);
    $display("test misc done");
  endtask
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  // ------------------------------------------------------------
  // Clock, reset, sequence and watchdog
  // ------------------------------------------------------------
  initial begin
    mclk_in = 0;
    forever #4 mclk_in = ~mclk_in;
  end
  initial begin
    bad_count = 0; total_checks = 0;
    nrst_in = 0; ce_in = 1; psel_in = 0; penable_in = 0; pwrite_in = 0; paddr_in = '0;
    pwdata_in = '0; pstrb_in = 4'hF; ch_valid_in = 0; ch_idx_in = '0; ch_data_in = '0;
    rbs_frame_in = 0; sig_bit_in = 0; stuff_req_in = 0;
    repeat (12) @(posedge mclk_in);
    nrst_in <= 1'b1;
    t_regs;
    t_modes;
    t_misc;
    report_and_stop;
  end
  // Whole run needs under a hundred cycles; this leaves ample margin
  initial begin
    #200000;
    bad_count++;
    report_and_stop;
  end
endmodule
